/* File: design/sma_pkg.sv */
package sma_pkg;
  // ********************************
  // Sizes and slot map
  // ********************************
  localparam int NUM_MEAS = 20;
  localparam int NUM_FAN  = 8;
  localparam int NUM_SLOT = 28;
  localparam int NUM_IO   = 17;
  localparam logic [4:0] SLOT_AIN8     = 5'h08;
  localparam logic [4:0] SLOT_AIN9     = 5'h09;
  localparam logic [4:0] SLOT_TEMP_LOC = 5'h11;
  localparam logic [4:0] SLOT_TEMP2    = 5'h13;
  localparam int STAT_THERMAL_ALARM_N   = 28;
  localparam int STAT_INTRUDE = 29;

  // ********************************
  // Register offsets and fields
  // ********************************
  localparam logic [7:0] ADDR_CFG     = 8'h00;
  localparam logic [7:0] ADDR_FAN_IO  = 8'h01;
  localparam logic [7:0] ADDR_DIR0    = 8'h02;
  localparam logic [7:0] ADDR_OUT0    = 8'h05;
  localparam logic [7:0] ADDR_IN0     = 8'h08;
  localparam logic [7:0] ADDR_INTRUDE = 8'h0b;
  localparam logic [7:0] ADDR_STAT0   = 8'h10;
  localparam logic [7:0] ADDR_CLR0    = 8'h14;
  localparam logic [7:0] ADDR_MASK0   = 8'h18;
  localparam logic [7:0] ADDR_VAL0    = 8'h20;
  localparam logic [7:0] ADDR_HI0     = 8'h40;
  localparam logic [7:0] ADDR_LO0     = 8'h60;
  localparam int CFG_RUN       = 0;
  localparam int CFG_D2_ANALOG = 1;
  localparam int CFG_THERMAL_ALARM_N     = 2;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [7:0]  FAN_IO_RST = 8'h00;
  localparam logic [23:0] DIR_RST    = 24'h000000;
  localparam logic [23:0] OUT_RST    = 24'h01ffff;
  localparam logic [23:0] IO_VALID   = 24'h01ffff;
  localparam logic [31:0] MASK_RST   = 32'h00000000;
  localparam logic [7:0]  HI_RST     = 8'hff;
  localparam logic [7:0]  LO_RST     = 8'h00;

  // ********************************
  // Timing
  // ********************************
  localparam longint CLK_PERIOD_PS = 5000;
  localparam longint RST_PULSE_MS  = 180;
  localparam longint RST_PULSE_CYC =
    (RST_PULSE_MS * 64'd1000000000) / CLK_PERIOD_PS;
  localparam longint FAN_TICK_NS   = 10000;
  localparam int     FAN_TICK_CYC  =
    32'((FAN_TICK_NS * 64'd1000) / CLK_PERIOD_PS);

  // ********************************
  // Types
  // ********************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sma_bus_req_type;

  typedef struct packed {
    logic       start;
    logic       tempMode;
    logic [4:0] chan;
  } sma_adc_req_type;

  typedef struct packed {
    logic       done;
    logic [7:0] data;
  } sma_adc_res_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PICK,
    SEQ_WAIT
  } sma_seq_state_type;
endpackage : sma_pkg

/* File: design/sma_monitor.sv */
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module sma_monitor #(
  parameter int unsigned RST_CYC = 32'(sma_pkg::RST_PULSE_CYC)
) (
  // Clock and resets
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     batRst,
  // Register port
  input  wire sma_pkg::sma_bus_req_type busReq,
  output logic [7:0]                    rdData,
  // Converter
  output sma_pkg::sma_adc_req_type      adcReq,
  input  wire sma_pkg::sma_adc_res_type adcRes,
  // General pins, 8..15 double as tach, 16 as alarm
  input  wire logic [16:0]              ioIn,
  output logic [16:0]                   ioOut,
  output logic [16:0]                   ioOe,
  // Rails, intrusion and resets
  input  wire logic                     stbyOk,
  input  wire logic                     mainOk,
  input  wire logic                     intrudeIn,
  input  wire logic                     mainRstIn,
  output logic                          mainRstOut,
  output logic                          mainRstOe,
  output logic                          stbyRstN,
  // Interrupt
  output logic                          intN
);
  // ********************************
  // Declarations
  // ********************************
  logic [20:0] syncA_r, syncB_r;
  logic [16:0] ioS;
  logic        stbyOkS, mainOkS, intrS, mainPinS;
  logic [7:0]  cfg_r, cfg_nxt, fanIo_r, fanIo_nxt;
  logic [23:0] dir_r, dir_nxt, out_r, out_nxt;
  logic [31:0] mask_r, mask_nxt, stat_r, stat_nxt, clr, evt;
  logic [7:0]  val_r [sma_pkg::NUM_SLOT];
  logic [7:0]  val_nxt [sma_pkg::NUM_SLOT];
  logic [7:0]  hi_r [sma_pkg::NUM_SLOT];
  logic [7:0]  hi_nxt [sma_pkg::NUM_SLOT];
  logic [7:0]  lo_r [sma_pkg::NUM_SLOT];
  logic [7:0]  lo_nxt [sma_pkg::NUM_SLOT];
  logic [7:0]  hiOff, loOff, valOff, rdData_nxt;
  sma_pkg::sma_seq_state_type state_r, state_nxt;
  logic [4:0]  slot_r, slot_nxt, slotNext;
  logic        slotOk, run, d2Analog;
  sma_pkg::sma_adc_req_type adcReq_r, adcReq_nxt;
  logic [2:0]  hot_r, hot_nxt;
  logic [10:0] tickCnt_r, tickCnt_nxt;
  logic        tick;
  wire  [7:0]  fanCntW [sma_pkg::NUM_FAN];
  wire  [7:0]  fanDone;
  logic        intr_r, intr_nxt, intrPrev_r, intrRise, intrClr;
  logic [25:0] stbyCnt_r, stbyCnt_nxt, mainCnt_r, mainCnt_nxt;
  logic        stbyRstN_r, stbyRstN_nxt, mainOe_r, mainOe_nxt;
  logic [1:0]  oeHist_r, mHist_r;
  logic        extRst, thermSense;
  logic [16:0] ioOe_r, ioOe_nxt;
  logic        intN_r, intN_nxt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ********************************
  // Pin synchronisers
  // ********************************
  // Two stages for every pin, only stage two is read
  always_ff @(posedge ref_clk) begin
    syncA_r <= {mainRstIn, intrudeIn, mainOk, stbyOk, ioIn};
    syncB_r <= syncA_r;
  end
  assign ioS      = syncB_r[16:0];
  assign stbyOkS  = syncB_r[17];
  assign mainOkS  = syncB_r[18];
  assign intrS    = syncB_r[19];
  assign mainPinS = syncB_r[20];

  // Sync lag would read our own release as a foreign pull
  assign extRst     = ~mainPinS & ~mainOe_r & ~|mHist_r;
  assign thermSense = cfg_r[sma_pkg::CFG_THERMAL_ALARM_N] & ~ioS[16]
                      & ~ioOe_r[16] & ~|oeHist_r;
  assign run        = cfg_r[sma_pkg::CFG_RUN];
  assign d2Analog   = cfg_r[sma_pkg::CFG_D2_ANALOG];
  assign hiOff      = busReq.addr - sma_pkg::ADDR_HI0;
  assign loOff      = busReq.addr - sma_pkg::ADDR_LO0;
  assign valOff     = busReq.addr - sma_pkg::ADDR_VAL0;

  // ********************************
  // Configuration and limits
  // ********************************
  // Only the register port changes setup; the reset pin restores all of it except the high and low limits
  always_comb begin
    cfg_nxt   = cfg_r;
    fanIo_nxt = fanIo_r;
    dir_nxt   = dir_r;
    out_nxt   = out_r;
    mask_nxt  = mask_r;
    hi_nxt    = hi_r;
    lo_nxt    = lo_r;
    clr       = '0;
    intrClr   = 1'b0;
    if (extRst) begin
      cfg_nxt   = sma_pkg::CFG_RST;
      fanIo_nxt = sma_pkg::FAN_IO_RST;
      dir_nxt   = sma_pkg::DIR_RST;
      out_nxt   = sma_pkg::OUT_RST;
      mask_nxt  = sma_pkg::MASK_RST;
    end else if (busReq.wr) begin
      if (busReq.addr == sma_pkg::ADDR_CFG)
        cfg_nxt = busReq.wdata;
      if (busReq.addr == sma_pkg::ADDR_FAN_IO)
        fanIo_nxt = busReq.wdata;
      if (busReq.addr == sma_pkg::ADDR_INTRUDE)
        intrClr = busReq.wdata[0];
      for (int k = 0; k < 3; k++) begin
        if (busReq.addr == sma_pkg::ADDR_DIR0 + 8'(k))
          dir_nxt[8*k +: 8] = busReq.wdata
                              & sma_pkg::IO_VALID[8*k +: 8];
        if (busReq.addr == sma_pkg::ADDR_OUT0 + 8'(k))
          out_nxt[8*k +: 8] = busReq.wdata
                              & sma_pkg::IO_VALID[8*k +: 8];
      end
      for (int k = 0; k < 4; k++) begin
        if (busReq.addr == sma_pkg::ADDR_CLR0 + 8'(k))
          clr[8*k +: 8] = busReq.wdata;
        if (busReq.addr == sma_pkg::ADDR_MASK0 + 8'(k))
          mask_nxt[8*k +: 8] = busReq.wdata;
      end
      if (hiOff < 8'(sma_pkg::NUM_SLOT))
        hi_nxt[hiOff[4:0]] = busReq.wdata;
      if (loOff < 8'(sma_pkg::NUM_SLOT))
        lo_nxt[loOff[4:0]] = busReq.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_r   <= sma_pkg::CFG_RST;
      fanIo_r <= sma_pkg::FAN_IO_RST;
      dir_r   <= sma_pkg::DIR_RST;
      out_r   <= sma_pkg::OUT_RST;
      mask_r  <= sma_pkg::MASK_RST;
      for (int i = 0; i < sma_pkg::NUM_SLOT; i++) begin
        hi_r[i] <= sma_pkg::HI_RST;
        lo_r[i] <= sma_pkg::LO_RST;
      end
    end else begin
      cfg_r   <= cfg_nxt;
      fanIo_r <= fanIo_nxt;
      dir_r   <= dir_nxt;
      out_r   <= out_nxt;
      mask_r  <= mask_nxt;
      hi_r    <= hi_nxt;
      lo_r    <= lo_nxt;
    end
  end

  a_ext_reset: assert property (extRst |=> cfg_r == 8'h00)
    else $error("external reset did not clear setup");

  // ********************************
  // Fan tick and tach counters
  // ********************************
  // Coarse tick keeps a slow fan inside an 8-bit count
  always_comb begin
    tick        = (tickCnt_r == 11'(sma_pkg::FAN_TICK_CYC - 1));
    tickCnt_nxt = tick ? '0 : tickCnt_r + 11'h001;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) tickCnt_r <= '0;
    else tickCnt_r <= tickCnt_nxt;
  end

  for (genvar f = 0; f < sma_pkg::NUM_FAN; f++) begin : g_fan
    logic [7:0] cnt_r, cnt_nxt;
    logic       prev_r, edgeF, done;
    // Falling tach edge ends a period; a stalled fan reads full
    always_comb begin
      edgeF   = prev_r & ~ioS[8+f] & ~fanIo_r[f];
      done    = edgeF | (tick & ~fanIo_r[f] & (cnt_r == 8'hff));
      cnt_nxt = cnt_r;
      if (fanIo_r[f] | done) cnt_nxt = '0;
      else if (tick && cnt_r != 8'hff) cnt_nxt = cnt_r + 8'h01;
    end
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        cnt_r  <= '0;
        prev_r <= 1'b1;
      end else begin
        cnt_r  <= cnt_nxt;
        prev_r <= ioS[8+f];
      end
    end
    assign fanCntW[f] = cnt_r;
    assign fanDone[f] = done;
  end

  // ********************************
  // Measurement sequencer
  // ********************************
  // Diode pair two is two analog slots or one temperature slot
  always_comb begin
    slotOk = 1'b1;
    if ((slot_r == sma_pkg::SLOT_AIN8 || slot_r == sma_pkg::SLOT_AIN9)
        && !d2Analog) slotOk = 1'b0;
    if (slot_r == sma_pkg::SLOT_TEMP2 && d2Analog) slotOk = 1'b0;
    slotNext = (slot_r == sma_pkg::SLOT_TEMP2) ? '0 : slot_r + 5'h01;
  end

  always_comb begin
    state_nxt        = state_r;
    slot_nxt         = slot_r;
    adcReq_nxt       = adcReq_r;
    adcReq_nxt.start = 1'b0;
    val_nxt          = val_r;
    hot_nxt          = hot_r;
    evt              = '0;
    case (state_r)
      sma_pkg::SEQ_IDLE: begin
        if (run) state_nxt = sma_pkg::SEQ_PICK;
      end
      sma_pkg::SEQ_PICK: begin
        if (!run) state_nxt = sma_pkg::SEQ_IDLE;
        else if (!slotOk) slot_nxt = slotNext;
        else begin
          adcReq_nxt.start    = 1'b1;
          adcReq_nxt.chan     = slot_r;
          adcReq_nxt.tempMode = (slot_r >= sma_pkg::SLOT_TEMP_LOC);
          state_nxt           = sma_pkg::SEQ_WAIT;
        end
      end
      sma_pkg::SEQ_WAIT: begin
        if (adcRes.done) begin
          val_nxt[slot_r] = adcRes.data;
          evt[slot_r]     = (adcRes.data > hi_r[slot_r])
                            | (adcRes.data < lo_r[slot_r]);
          if (slot_r >= sma_pkg::SLOT_TEMP_LOC)
            hot_nxt[2'(slot_r - sma_pkg::SLOT_TEMP_LOC)] =
              adcRes.data > hi_r[slot_r];
          slot_nxt  = slotNext;
          state_nxt = run ? sma_pkg::SEQ_PICK : sma_pkg::SEQ_IDLE;
        end
      end
      default: state_nxt = sma_pkg::SEQ_IDLE;
    endcase
    // Fans report concurrently into their own slots
    for (int f = 0; f < sma_pkg::NUM_FAN; f++) begin
      if (fanDone[f]) begin
        val_nxt[sma_pkg::NUM_MEAS+f] = fanCntW[f];
        evt[sma_pkg::NUM_MEAS+f] =
          fanCntW[f] > hi_r[sma_pkg::NUM_MEAS+f];
      end
    end
    evt[sma_pkg::STAT_THERMAL_ALARM_N]   = thermSense;
    evt[sma_pkg::STAT_INTRUDE] = intrRise;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r  <= sma_pkg::SEQ_IDLE;
      slot_r   <= '0;
      adcReq_r <= '0;
      hot_r    <= '0;
      for (int i = 0; i < sma_pkg::NUM_SLOT; i++) val_r[i] <= '0;
    end else begin
      state_r  <= state_nxt;
      slot_r   <= slot_nxt;
      adcReq_r <= adcReq_nxt;
      hot_r    <= hot_nxt;
      val_r    <= val_nxt;
    end
  end

  sequence s_meas_done;
    state_r == sma_pkg::SEQ_WAIT && adcRes.done;
  endsequence
  sequence s_pick_go;
    state_r == sma_pkg::SEQ_PICK && run && slotOk;
  endsequence

  a_seq_start: assert property (
    s_pick_go |=> adcReq.start ##1 !adcReq.start)
    else $error("sequencer did not issue one start pulse");
  a_store_value: assert property (
    s_meas_done |=> val_r[$past(slot_r)] == $past(adcRes.data))
    else $error("result not stored in its slot");
  a_status_set: assert property (
    s_meas_done and (adcRes.data > hi_r[slot_r])
    |=> stat_r[$past(slot_r)])
    else $error("high miss did not set status");
  // Mode is judged one cycle back, when the slot was picked
  a_skip_d2: assert property (
    adcReq.start |-> ($past(d2Analog)
      ? adcReq.chan != sma_pkg::SLOT_TEMP2
      : (adcReq.chan != sma_pkg::SLOT_AIN8
         && adcReq.chan != sma_pkg::SLOT_AIN9)))
    else $error("diode pair two sampled in wrong mode");
  a_fan_store: assert property (
    fanDone[0] |=> val_r[sma_pkg::NUM_MEAS] == $past(fanCntW[0]))
    else $error("fan result not stored");

  // ********************************
  // Status, mask and interrupt
  // ********************************
  // Set beats clear; mask never stops the status bit
  always_comb begin
    stat_nxt = (stat_r & ~clr) | evt;
    intN_nxt = ~|(stat_nxt & ~mask_nxt);
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_r <= '0;
      intN_r <= 1'b1;
    end else begin
      stat_r <= stat_nxt;
      intN_r <= intN_nxt;
    end
  end

  a_int_level: assert property (intN == ~|(stat_r & ~mask_r))
    else $error("interrupt does not match unmasked status");
  a_mask_keeps: assert property (
    |(evt & mask_r) |=>
      (stat_r & $past(evt & mask_r)) == $past(evt & mask_r)
      && (intN || |(stat_r & ~mask_r)))
    else $error("masked source misbehaved");

  // ********************************
  // Chassis intrusion (battery domain)
  // ********************************
  // Survives the main reset; only battery reset or a write clears it
  always_comb begin
    intrRise = intrS & ~intrPrev_r;
    intr_nxt = (intr_r & ~intrClr) | intrRise;
  end
  always_ff @(posedge ref_clk) begin
    if (batRst) begin
      intr_r     <= 1'b0;
      intrPrev_r <= 1'b0;
    end else begin
      intr_r     <= intr_nxt;
      intrPrev_r <= intrS;
    end
  end

  a_intr_latch: assert property (intr_r && !intrClr |=> intr_r)
    else $error("intrusion bit lost");

  // ********************************
  // Rail resets
  // ********************************
  // Main count starts only once standby has released
  always_comb begin
    stbyCnt_nxt  = stbyCnt_r;
    stbyRstN_nxt = stbyRstN_r;
    mainCnt_nxt  = mainCnt_r;
    mainOe_nxt   = mainOe_r;
    if (!stbyOkS) begin
      stbyCnt_nxt  = '0;
      stbyRstN_nxt = 1'b0;
    end else if (stbyCnt_r == 26'(RST_CYC - 1)) stbyRstN_nxt = 1'b1;
    else stbyCnt_nxt = stbyCnt_r + 26'h1;
    if (!mainOkS || !stbyRstN_r) begin
      mainCnt_nxt = '0;
      mainOe_nxt  = 1'b1;
    end else if (mainCnt_r == 26'(RST_CYC - 1)) mainOe_nxt = 1'b0;
    else mainCnt_nxt = mainCnt_r + 26'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stbyCnt_r  <= '0;
      stbyRstN_r <= 1'b0;
      mainCnt_r  <= '0;
      mainOe_r   <= 1'b1;
      mHist_r    <= 2'b11;
    end else begin
      stbyCnt_r  <= stbyCnt_nxt;
      stbyRstN_r <= stbyRstN_nxt;
      mainCnt_r  <= mainCnt_nxt;
      mainOe_r   <= mainOe_nxt;
      mHist_r    <= {mHist_r[0], mainOe_r};
    end
  end

  a_stby_low: assert property (!stbyOkS |=> !stbyRstN)
    else $error("standby reset not held while rail low");
  a_main_after: assert property (
    $fell(mainOe_r) |-> mainCnt_r == 26'(RST_CYC - 1) && stbyRstN_r)
    else $error("main reset released too early");

  // ********************************
  // Open-drain pin drive
  // ********************************
  // Pins only pull low; alarm pin follows any hot temperature
  always_comb begin
    for (int i = 0; i < sma_pkg::NUM_IO; i++)
      ioOe_nxt[i] = dir_nxt[i] & ~out_nxt[i];
    ioOe_nxt[15:8] = ioOe_nxt[15:8] & fanIo_nxt;
    if (cfg_nxt[sma_pkg::CFG_THERMAL_ALARM_N]) ioOe_nxt[16] = |hot_nxt;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ioOe_r   <= '0;
      oeHist_r <= '0;
    end else begin
      ioOe_r   <= ioOe_nxt;
      oeHist_r <= {oeHist_r[0], ioOe_r[16]};
    end
  end

  a_od_only: assert property (ioOut == '0 && !mainRstOut)
    else $error("open-drain pin driven high");
  a_thermal_alarm_n_drive: assert property (
    cfg_r[sma_pkg::CFG_THERMAL_ALARM_N] |-> ioOe[16] == |hot_r)
    else $error("alarm pin does not follow temperature");

  // ********************************
  // Read port
  // ********************************
  // Unmapped and write-only offsets read zero
  always_comb begin
    rdData_nxt = 8'h00;
    if (busReq.rd) begin
      for (int k = 0; k < 3; k++) begin
        if (busReq.addr == sma_pkg::ADDR_DIR0 + 8'(k))
          rdData_nxt = dir_r[8*k +: 8];
        if (busReq.addr == sma_pkg::ADDR_OUT0 + 8'(k))
          rdData_nxt = out_r[8*k +: 8];
        if (busReq.addr == sma_pkg::ADDR_IN0 + 8'(k))
          rdData_nxt = 8'({7'h00, ioS} >> (8*k));
      end
      for (int k = 0; k < 4; k++) begin
        if (busReq.addr == sma_pkg::ADDR_STAT0 + 8'(k))
          rdData_nxt = stat_r[8*k +: 8];
        if (busReq.addr == sma_pkg::ADDR_MASK0 + 8'(k))
          rdData_nxt = mask_r[8*k +: 8];
      end
      if (busReq.addr == sma_pkg::ADDR_CFG) rdData_nxt = cfg_r;
      if (busReq.addr == sma_pkg::ADDR_FAN_IO) rdData_nxt = fanIo_r;
      if (busReq.addr == sma_pkg::ADDR_INTRUDE)
        rdData_nxt = {7'h00, intr_r};
      if (valOff < 8'(sma_pkg::NUM_SLOT))
        rdData_nxt = val_r[valOff[4:0]];
      if (hiOff < 8'(sma_pkg::NUM_SLOT)) rdData_nxt = hi_r[hiOff[4:0]];
      if (loOff < 8'(sma_pkg::NUM_SLOT)) rdData_nxt = lo_r[loOff[4:0]];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) rdData <= 8'h00;
    else rdData <= rdData_nxt;
  end

  // Output drive
  assign adcReq     = adcReq_r;
  assign ioOe       = ioOe_r;
  assign ioOut      = '0;
  assign mainRstOut = 1'b0;
  assign mainRstOe  = mainOe_r;
  assign stbyRstN   = stbyRstN_r;
  assign intN       = intN_r;
endmodule : sma_monitor

/* File: bench/sma_adc_model.sv */
`timescale 1ns/1ps
module sma_adc_model (
  // Clock
  input  wire logic                     ref_clk,
  // Converter side
  input  wire sma_pkg::sma_adc_req_type adcReq,
  output sma_pkg::sma_adc_res_type      adcRes
);
  // ****************************************
  // Converter stand-in
  // ****************************************
  int chanQ[$];

  // Latency varies from 1 to 4 cycles, so prompt and slow answers both occur
  initial begin
    adcRes = '0;
    forever begin
      @(posedge ref_clk);
      if (adcReq.start) begin
        chanQ.push_back(int'(adcReq.chan));
        repeat (1 + chanQ.size() % 4) @(posedge ref_clk);
        adcRes <= '{done: 1'b1, data: 8'(adcReq.chan * 37 + 11)};
        @(posedge ref_clk);
        // Stale data is inverted so a late sample cannot pass by luck
        adcRes <= '{done: 1'b0, data: ~adcRes.data};
      end
    end
  end
endmodule : sma_adc_model

/* File: bench/system_monitor_limit_alarm_tb.sv */
`timescale 1ns/1ps
module system_monitor_limit_alarm_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic                     ref_clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     batRst = 1'b1;
  sma_pkg::sma_bus_req_type busReq = '0;
  logic [7:0]               rdData;
  sma_pkg::sma_adc_req_type adcReq;
  sma_pkg::sma_adc_res_type adcRes;
  logic [16:0]              ioIn, ioOut, ioOe;
  logic                     stbyOk = 1'b0;
  logic                     mainOk = 1'b0;
  logic                     intrudeIn = 1'b0;
  logic                     extLow = 1'b0;
  logic                     tach = 1'b1;
  logic                     extAlarm = 1'b0;
  logic                     mainRstIn, mainRstOut, mainRstOe, stbyRstN, intN;
  int                       errors = 0;
  int                       checked = 0;
  int                       cyc = 0;
  logic [7:0]               rv, hi3;

  // Pull-ups on every pin; any party pulling low wins
  assign ioIn      = ~ioOe & {~extAlarm, 7'h7f, tach, 8'hff};
  assign mainRstIn = ~(mainRstOe | extLow);

  always #2.5 ref_clk = ~ref_clk;

  sma_monitor #(.RST_CYC(20)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .batRst(batRst), .busReq(busReq),
    .rdData(rdData), .adcReq(adcReq), .adcRes(adcRes), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .stbyOk(stbyOk), .mainOk(mainOk),
    .intrudeIn(intrudeIn), .mainRstIn(mainRstIn), .mainRstOut(mainRstOut),
    .mainRstOe(mainRstOe), .stbyRstN(stbyRstN), .intN(intN)
  );

  sma_adc_model i_adc (.ref_clk(ref_clk), .adcReq(adcReq), .adcRes(adcRes));

  // ****************************************
  // Helpers
  // ****************************************
  // Reference result per slot, kept apart from the model on purpose
  function automatic logic [7:0] dat(input int c);
    return 8'(c * 37 + 11);
  endfunction : dat

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen,
               expv);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    busReq <= '0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    busReq <= '0;
    #1 d = rdData;
  endtask : rd

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hf2074595));
    repeat (20) @(posedge ref_clk);
    rst    <= 1'b0;
    batRst <= 1'b0;
    // Rails come up together
    stbyOk <= 1'b1;
    mainOk <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(stbyRstN, 1'b0);
    for (int n = 0; n < 40 && stbyRstN !== 1'b1; n++) @(posedge ref_clk);
    chk(mainRstOe, 1'b1);
    for (int n = 0; n < 40 && mainRstOe !== 1'b0; n++) @(posedge ref_clk);
    chk(mainRstOe, 1'b0);
    // Defaults and an unmapped offset
    rd(sma_pkg::ADDR_OUT0, rv);
    chk(rv, 8'hff);
    rd(sma_pkg::ADDR_HI0, rv);
    chk(rv, 8'hff);
    rd(8'h80, rv);
    chk(rv, 8'h00);
    chk(intN, 1'b1);
    // Another party pulls the alarm pin while the device is idle
    wr(sma_pkg::ADDR_CFG, 8'h04);
    extAlarm <= 1'b1;
    repeat (5) @(posedge ref_clk);
    extAlarm <= 1'b0;
    rd(sma_pkg::ADDR_STAT0 + 8'h03, rv);
    chk(rv, 8'h10);
    wr(sma_pkg::ADDR_CLR0 + 8'h03, 8'h10);
    // Slot 3 above its high limit, slot 5 below its low limit
    hi3 = 8'($urandom % dat(3));
    wr(sma_pkg::ADDR_HI0 + 8'h03, hi3);
    wr(sma_pkg::ADDR_LO0 + 8'h05, dat(5) + 8'h01);
    wr(sma_pkg::ADDR_MASK0, 8'h08);
    wr(sma_pkg::ADDR_CFG, 8'h01);
    repeat (400) @(posedge ref_clk);
    chk(intN, 1'b0);
    wr(sma_pkg::ADDR_CFG, 8'h00);
    repeat (20) @(posedge ref_clk);
    // Diode pair as temperature: slots 8 and 9 skipped
    for (int i = 0; i < 12; i++)
      chk(i_adc.chanQ[i], (i < 8) ? i : i + 2);
    rd(sma_pkg::ADDR_VAL0 + 8'h03, rv);
    chk(rv, dat(3));
    rd(sma_pkg::ADDR_VAL0 + 8'h08, rv);
    chk(rv, 8'h00);
    rd(sma_pkg::ADDR_STAT0, rv);
    chk(rv, 8'h28);
    wr(sma_pkg::ADDR_MASK0, 8'h28);
    repeat (2) @(posedge ref_clk);
    chk(intN, 1'b1);
    wr(sma_pkg::ADDR_CLR0, 8'h28);
    rd(sma_pkg::ADDR_STAT0, rv);
    chk(rv, 8'h00);
    // Diode pair as two analog slots; hot local temp pulls pin 16
    wr(sma_pkg::ADDR_HI0 + 8'h11, 8'h10);
    wr(sma_pkg::ADDR_CFG, 8'h07);
    repeat (400) @(posedge ref_clk);
    chk(ioOe[16], 1'b1);
    wr(sma_pkg::ADDR_CFG, 8'h00);
    rd(sma_pkg::ADDR_VAL0 + 8'h08, rv);
    chk(rv, dat(8));
    chk(ioOe[16], 1'b0);
    // Pin 0 as output pulling low
    wr(sma_pkg::ADDR_DIR0, 8'h01);
    wr(sma_pkg::ADDR_OUT0, 8'hfe);
    repeat (5) @(posedge ref_clk);
    chk(ioOe[0], 1'b1);
    rd(sma_pkg::ADDR_IN0, rv);
    chk(rv, 8'hfe);
    chk({ioOut, mainRstOut}, 18'h00000);
    // Another party pulls the main reset pin
    extLow <= 1'b1;
    repeat (5) @(posedge ref_clk);
    extLow <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(sma_pkg::ADDR_DIR0, rv);
    chk(rv, 8'h00);
    rd(sma_pkg::ADDR_MASK0, rv);
    chk(rv, 8'h00);
    // Intrusion pulse stays latched
    intrudeIn <= 1'b1;
    repeat (5) @(posedge ref_clk);
    intrudeIn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd(sma_pkg::ADDR_INTRUDE, rv);
    chk(rv, 8'h01);
    rd(sma_pkg::ADDR_STAT0 + 8'h03, rv);
    chk(rv, 8'h20);
    // Tach on pin 8: falls 25 us apart span two or three 10 us ticks
    tach <= 1'b0;
    repeat (4) @(posedge ref_clk);
    tach <= 1'b1;
    repeat (4996) @(posedge ref_clk);
    tach <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rd(sma_pkg::ADDR_VAL0 + 8'h14, rv);
    chk(rv == 8'h02 || rv == 8'h03, 1'b1);
    stop_test();
  end
endmodule : system_monitor_limit_alarm_tb
